// file: verilog/mcr_regs.sv
// Monitor configuration and identity register bank behind a 24-bit serial port.
// Assumes serial pins synchronous to ref_clk_in; sense samples arrive as strobes.
//
// Notes on behaviour
// - A two-bit power-state select sits in bits 1 to 0 of the power register and resets to power-down.
// - Codes 00 and 01 mean power-down, 10 means active, and the host must never write 11.
// - The part identity register at offset 0x04 returns a fixed 16-bit code.
// - The revision identity register at offset 0x06 returns a 16-bit code that may change between revisions.
// - The maker identity register at offset 0x0c returns a fixed 16-bit code.
// - Configuration bit 12 picks free-running conversion at 0 and direct conversion at 1, resetting to 0.
// - Sense results pass a one-pole recursive average whose depth K comes from bits 10 to 8, reset 011.
// - Depth codes 000 to 100 give K of 1, 2, 4, 8 and 16, and the host must not write 101 to 111.
// - Bits 6 to 4 pick the remote temperature averaging, reset 000, with codes above 101 invalid.
// - Configuration bit 0 turns on closed-loop drain-current control and resets to off.
// - Reserved configuration bits are stored read-write, reset to zero, and the host keeps them there.
// - The general configuration register at offset 0x10 resets to 0x0300 as a whole.
// - Each access is one 24-bit frame under chip select: read flag, seven address bits, sixteen data bits, MSB first.
// - Write bits are taken on rising clock edges, short or long write frames are dropped, read bits leave on falling edges.
`timescale 1ns/10ps
module mcr_regs
#(
  parameter logic [15:0] PART_CODE = 16'h1a2b, // Arbitrary value
  parameter logic [15:0] REVISION_CODE = 16'h0003, // Arbitrary value
  parameter logic [15:0] MAKER_CODE = 16'h3c5d // Arbitrary value
)
(
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic sdo_oe_n_out,
  input wire logic [11:0] cs_sample_in,
  input wire logic cs_sample_valid_in,
  output logic [11:0] cs_filtered_out,
  output logic active_mode_out,
  output logic conversion_trigger_select_out,
  output logic [2:0] remote_temp_average_select_out,
  output logic loop_enable_out
);
  mcr_reg_if reg_if();

  logic [15:0] power_state, next_power_state;
  logic [15:0] general_config_zero, next_general_config_zero;
  logic [15:0] filt_acc, next_filt_acc;
  logic active_mode, next_active_mode;
  logic trig_sel, next_trig_sel;
  logic [2:0] rt_avg, next_rt_avg;
  logic loop_en, next_loop_en;
  logic [15:0] rdata;
  logic [2:0] filt_shift;
  logic signed [17:0] filt_diff;
  logic signed [17:0] filt_step;

  // Serial frame engine
  mcr_spi_frame u_frame
  (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .sclk_in(sclk_in),
    .cs_n_in(cs_n_in),
    .sdi_in(sdi_in),
    .sdo_out(sdo_out),
    .sdo_oe_n_out(sdo_oe_n_out),
    .reg_if(reg_if.frame)
  );

  // Read mux; unmapped and reserved offsets read as zero
  always_comb
  begin
    unique case (reg_if.addr)
      mcr_pkg::OFS_POWER_STATE: rdata = power_state;
      mcr_pkg::OFS_PART_IDENTITY: rdata = PART_CODE;
      mcr_pkg::OFS_REVISION_IDENTITY: rdata = REVISION_CODE;
      mcr_pkg::OFS_MAKER_IDENTITY: rdata = MAKER_CODE;
      mcr_pkg::OFS_GENERAL_CONFIG_ZERO: rdata = general_config_zero;
      default: rdata = 16'h0000;
    endcase
  end

  // Mux is combinational; the frame engine latches it one cycle after rd_en
  assign reg_if.rdata = rdata;

  // Register writes; identity offsets fall through and change nothing
  always_comb
  begin
    next_power_state = power_state;
    next_general_config_zero = general_config_zero;
    if (reg_if.wr_en)
    begin
      unique case (reg_if.addr)
        // Reserved bits are kept as plain storage, not masked
        mcr_pkg::OFS_POWER_STATE: next_power_state = reg_if.wdata;
        mcr_pkg::OFS_GENERAL_CONFIG_ZERO: next_general_config_zero = reg_if.wdata;
        default: next_power_state = power_state;
      endcase
    end
  end

  // Register storage
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      power_state <= mcr_pkg::RST_POWER_STATE;
      general_config_zero <= mcr_pkg::RST_GENERAL_CONFIG_ZERO;
    end
    else
    begin
      power_state <= next_power_state;
      general_config_zero <= next_general_config_zero;
    end
  end

  // Field decode into registered control outputs
  always_comb
  begin
    // Code 11 is not honoured as active; only the exact active code powers up
    next_active_mode = power_state[mcr_pkg::POWER_LSB +: 2] == mcr_pkg::POWER_ACTIVE;
    next_trig_sel = general_config_zero[mcr_pkg::TRIG_SEL_BIT];
    next_rt_avg = general_config_zero[mcr_pkg::RT_AVG_LSB +: 3];
    next_loop_en = general_config_zero[mcr_pkg::LOOP_EN_BIT];
  end

  // Outputs registered so that top-level pins come straight from flops
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      active_mode <= 1'b0;
      trig_sel <= 1'b0;
      rt_avg <= 3'h0;
      loop_en <= 1'b0;
    end
    else
    begin
      active_mode <= next_active_mode;
      trig_sel <= next_trig_sel;
      rt_avg <= next_rt_avg;
      loop_en <= next_loop_en;
    end
  end

  // Depth select, clamped so a forbidden code cannot overrun the shifter
  always_comb
  begin
    if (general_config_zero[mcr_pkg::CS_FILT_LSB +: 3] > mcr_pkg::CS_FILT_MAX)
      filt_shift = mcr_pkg::CS_FILT_MAX;
    else
      filt_shift = general_config_zero[mcr_pkg::CS_FILT_LSB +: 3];
  end

  // One-pole average y += (x - y) / K, kept with four fraction bits
  always_comb
  begin
    filt_diff = $signed({2'b00, cs_sample_in, 4'h0}) - $signed({2'b00, filt_acc});
    filt_step = filt_diff >>> filt_shift;
    next_filt_acc = filt_acc;
    // Converter is off in power-down, so the average holds its value
    if (cs_sample_valid_in && active_mode)
      next_filt_acc = filt_acc + filt_step[15:0];
  end

  // Accumulator; power-down freezes it rather than clearing it
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      filt_acc <= 16'h0000;
    else
      filt_acc <= next_filt_acc;
  end

  // Top-level outputs, each taken from a register
  assign cs_filtered_out = filt_acc[15:4];
  assign active_mode_out = active_mode;
  assign conversion_trigger_select_out = trig_sel;
  assign remote_temp_average_select_out = rt_avg;
  assign loop_enable_out = loop_en;

  // Register and decode checks
  a_power_write_taken: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (reg_if.wr_en && reg_if.addr == mcr_pkg::OFS_POWER_STATE) |=> power_state == $past(reg_if.wdata))
    else $error("Power register did not take written value");

  a_active_decode: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (reg_if.wr_en && reg_if.addr == mcr_pkg::OFS_POWER_STATE) |=> ##1
      active_mode_out == ($past(reg_if.wdata[1:0], 2) == 2'h2))
    else $error("Active mode output does not follow power code");

  a_part_read: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (reg_if.rd_en && reg_if.addr == mcr_pkg::OFS_PART_IDENTITY) |-> reg_if.rdata == PART_CODE)
    else $error("Part identity read wrong");

  a_revision_read: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (reg_if.rd_en && reg_if.addr == mcr_pkg::OFS_REVISION_IDENTITY) |-> reg_if.rdata == REVISION_CODE)
    else $error("Revision identity read wrong");

  a_maker_read: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (reg_if.rd_en && reg_if.addr == mcr_pkg::OFS_MAKER_IDENTITY) |-> reg_if.rdata == MAKER_CODE)
    else $error("Maker identity read wrong");

  a_trigger_select: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (reg_if.wr_en && reg_if.addr == mcr_pkg::OFS_GENERAL_CONFIG_ZERO) |=> ##1
      conversion_trigger_select_out == $past(reg_if.wdata[12], 2))
    else $error("Conversion select output does not follow bit 12");

  a_filter_hold: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !active_mode |=> $stable(cs_filtered_out))
    else $error("Filter moved while powered down");

  a_loop_enable: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (reg_if.wr_en && reg_if.addr == mcr_pkg::OFS_GENERAL_CONFIG_ZERO) |=> ##1
      loop_enable_out == $past(reg_if.wdata[0], 2) && remote_temp_average_select_out == $past(reg_if.wdata[6:4], 2))
    else $error("Loop enable or remote average output wrong");

  a_identity_ignored: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (reg_if.wr_en && reg_if.addr != mcr_pkg::OFS_POWER_STATE && reg_if.addr != mcr_pkg::OFS_GENERAL_CONFIG_ZERO)
      |=> $stable(power_state) && $stable(general_config_zero))
    else $error("Write to other offset changed a register");

  // Storage follows committed writes only; reads and idle cycles leave it alone
  a_config_write_taken: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (reg_if.wr_en && reg_if.addr == mcr_pkg::OFS_GENERAL_CONFIG_ZERO)
      |=> general_config_zero == $past(reg_if.wdata))
    else $error("Configuration register did not take written value");

  a_regs_need_write: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !reg_if.wr_en
      |=> $stable(power_state) && $stable(general_config_zero))
    else $error("Register changed without a committed write");

  a_read_keeps_regs: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    reg_if.rd_en
      |=> $stable(power_state) && $stable(general_config_zero))
    else $error("Register changed by a read frame");

  a_unmapped_zero: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (reg_if.rd_en && reg_if.addr != mcr_pkg::OFS_POWER_STATE && reg_if.addr != mcr_pkg::OFS_PART_IDENTITY
      && reg_if.addr != mcr_pkg::OFS_REVISION_IDENTITY && reg_if.addr != mcr_pkg::OFS_MAKER_IDENTITY
      && reg_if.addr != mcr_pkg::OFS_GENERAL_CONFIG_ZERO) |-> reg_if.rdata == 16'h0000)
    else $error("Unmapped offset did not read as zero");

  // Reset checks carry no disable so that they see the first edge after release
  a_reset_power_value: assert property (@(posedge ref_clk_in)
    $fell(sys_rst_in)
      |-> power_state == mcr_pkg::RST_POWER_STATE)
    else $error("Power register not at reset value after reset");

  a_reset_config_value: assert property (@(posedge ref_clk_in)
    $fell(sys_rst_in)
      |-> general_config_zero == mcr_pkg::RST_GENERAL_CONFIG_ZERO)
    else $error("Configuration register not at reset value after reset");

  a_reset_outputs_low: assert property (@(posedge ref_clk_in)
    $fell(sys_rst_in)
      |-> !active_mode_out && !conversion_trigger_select_out && !loop_enable_out
        && remote_temp_average_select_out == 3'h0)
    else $error("Decoded outputs not low after reset");

  a_filter_reset: assert property (@(posedge ref_clk_in)
    $fell(sys_rst_in)
      |-> cs_filtered_out == 12'h000)
    else $error("Filter output not cleared by reset");

  // Decoded outputs move only two cycles after a committed write
  a_active_on_write: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    $changed(active_mode_out)
      |-> $past(reg_if.wr_en, 2))
    else $error("Active mode changed without a write");

  a_trigger_on_write: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    $changed(conversion_trigger_select_out)
      |-> $past(reg_if.wr_en, 2))
    else $error("Conversion select changed without a write");

  a_loop_on_write: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    $changed(loop_enable_out)
      |-> $past(reg_if.wr_en, 2))
    else $error("Loop enable changed without a write");

  // Power codes 00 and 01 both leave the analog side down
  a_powerdown_low_code: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !power_state[mcr_pkg::POWER_LSB + 1]
      |=> !active_mode_out)
    else $error("Active mode raised by a power-down code");

  a_active_only_code: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    active_mode_out
      |-> $past(power_state[mcr_pkg::POWER_LSB +: 2]) == mcr_pkg::POWER_ACTIVE)
    else $error("Active mode without the active code");

  // Filter behaviour against the depth rule, not against the arithmetic above
  a_filter_unity: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (cs_sample_valid_in && active_mode && general_config_zero[mcr_pkg::CS_FILT_LSB +: 3] == 3'h0)
      |=> cs_filtered_out == $past(cs_sample_in))
    else $error("Depth one did not pass the sample through");

  a_filter_toward: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (cs_sample_valid_in && active_mode && cs_sample_in >= cs_filtered_out)
      |=> cs_filtered_out >= $past(cs_filtered_out) && cs_filtered_out <= $past(cs_sample_in))
    else $error("Filter stepped away from or past the sample");
endmodule

// file: pkg/mcr_pkg.sv
// Constants for the monitor configuration and identity register bank.
// Assumes a 16-bit register space reached by a 24-bit serial frame.
package mcr_pkg;
  // Serial frame layout
  localparam int FRAME_BITS = 24;
  localparam int HEAD_BITS = 8;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam logic [4:0] FRAME_LEN = 5'h18;
  localparam logic [4:0] HEAD_LEN = 5'h08;
  localparam logic [4:0] CNT_OVER = 5'h19;
  localparam logic RW_READ = 1'b1;

  // Register offsets
  localparam logic [6:0] OFS_POWER_STATE = 7'h02;
  localparam logic [6:0] OFS_PART_IDENTITY = 7'h04;
  localparam logic [6:0] OFS_REVISION_IDENTITY = 7'h06;
  localparam logic [6:0] OFS_MAKER_IDENTITY = 7'h0c;
  localparam logic [6:0] OFS_GENERAL_CONFIG_ZERO = 7'h10;

  // Reset values
  localparam logic [15:0] RST_POWER_STATE = 16'h0000;
  localparam logic [15:0] RST_GENERAL_CONFIG_ZERO = 16'h0300;

  // Power state field
  localparam int POWER_LSB = 0;
  localparam logic [1:0] POWER_ACTIVE = 2'h2;

  // General configuration zero fields
  localparam int TRIG_SEL_BIT = 12;
  localparam int CS_FILT_LSB = 8;
  localparam int RT_AVG_LSB = 4;
  localparam int LOOP_EN_BIT = 0;
  localparam logic [2:0] CS_FILT_MAX = 3'h4;

  // Sense sample and filter accumulator widths
  localparam int SAMPLE_W = 12;
  localparam int FRAC_W = 4;
endpackage

// file: pkg/mcr_reg_if.sv
// Internal carrier between the serial frame engine and the register bank.
// Assumes both ends run on the same reference clock.
`timescale 1ns/10ps
interface mcr_reg_if;
  logic wr_en;
  logic rd_en;
  logic [6:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;

  modport frame
  (
    output wr_en,
    output rd_en,
    output addr,
    output wdata,
    input rdata
  );

  modport bank
  (
    input wr_en,
    input rd_en,
    input addr,
    input wdata,
    output rdata
  );
endinterface

// file: verilog/mcr_spi_frame.sv
// Serial frame engine: 24-bit frames in, register requests out.
// Assumes serial pins are synchronous to ref_clk_in, each clock phase >= 2 cycles.
`timescale 1ns/10ps
module mcr_spi_frame
(
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic sdo_oe_n_out,
  mcr_reg_if.frame reg_if
);
  typedef enum logic {MCR_IDLE, MCR_ACTIVE} mcr_frame_state_t;

  mcr_frame_state_t state, next_state;
  logic [4:0] cnt, next_cnt;
  logic [23:0] sh_in, next_sh_in;
  logic [15:0] sh_out, next_sh_out;
  logic rd_frame, next_rd_frame;
  logic sclk_q, next_sclk_q;
  logic sdo, next_sdo;
  logic sdo_oe_n, next_sdo_oe_n;
  logic wr_en, next_wr_en;
  logic rd_en, next_rd_en;
  logic [6:0] addr, next_addr;
  logic [15:0] wdata, next_wdata;
  logic rise;
  logic fall;

  assign rise = sclk_in & ~sclk_q;
  assign fall = ~sclk_in & sclk_q;

  // Frame sequencing, shifting and commit decision
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_sh_in = sh_in;
    next_sh_out = sh_out;
    next_rd_frame = rd_frame;
    next_sclk_q = sclk_in;
    next_sdo = sdo;
    next_sdo_oe_n = sdo_oe_n;
    next_wr_en = 1'b0;
    next_rd_en = 1'b0;
    next_addr = addr;
    next_wdata = wdata;
    if (cs_n_in)
    begin
      next_state = MCR_IDLE;
      next_cnt = 5'h00;
      next_sdo_oe_n = 1'b1;
      next_rd_frame = 1'b0;
      // Only a complete write frame is committed
      if (state == MCR_ACTIVE && cnt == mcr_pkg::FRAME_LEN && !rd_frame)
      begin
        next_wr_en = 1'b1;
        next_addr = sh_in[22:16];
        next_wdata = sh_in[15:0];
      end
    end
    else if (state == MCR_IDLE)
    begin
      // Edge seen in the select cycle itself is dropped; host must idle first
      next_state = MCR_ACTIVE;
      next_cnt = 5'h00;
    end
    else
    begin
      if (rise)
      begin
        next_sh_in = {sh_in[22:0], sdi_in};
        // Saturate so that over-long frames stay invalid
        if (cnt != mcr_pkg::CNT_OVER)
          next_cnt = cnt + 5'h01;
        if (cnt == mcr_pkg::HEAD_LEN - 5'h01 && sh_in[6] == mcr_pkg::RW_READ)
        begin
          next_rd_frame = 1'b1;
          next_rd_en = 1'b1;
          next_addr = {sh_in[5:0], sdi_in};
        end
      end
      // Read data captured the cycle after the request
      if (rd_en)
        next_sh_out = reg_if.rdata;
      else if (fall && rd_frame)
      begin
        next_sdo = sh_out[15];
        next_sh_out = {sh_out[14:0], 1'b0};
        next_sdo_oe_n = 1'b0;
      end
    end
  end

  // State registers
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state <= MCR_IDLE;
      cnt <= 5'h00;
      sh_in <= 24'h000000;
      sh_out <= 16'h0000;
      rd_frame <= 1'b0;
      sclk_q <= 1'b0;
      sdo <= 1'b0;
      sdo_oe_n <= 1'b1;
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      addr <= 7'h00;
      wdata <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      sh_in <= next_sh_in;
      sh_out <= next_sh_out;
      rd_frame <= next_rd_frame;
      sclk_q <= next_sclk_q;
      sdo <= next_sdo;
      sdo_oe_n <= next_sdo_oe_n;
      wr_en <= next_wr_en;
      rd_en <= next_rd_en;
      addr <= next_addr;
      wdata <= next_wdata;
    end
  end

  assign sdo_out = sdo;
  assign sdo_oe_n_out = sdo_oe_n;
  assign reg_if.wr_en = wr_en;
  assign reg_if.rd_en = rd_en;
  assign reg_if.addr = addr;
  assign reg_if.wdata = wdata;

  a_short_write_drop: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (cs_n_in && state == MCR_ACTIVE && cnt != mcr_pkg::FRAME_LEN) |=> !wr_en)
    else $error("Write committed from a frame without exactly 24 clocks");

  a_sdo_read_only: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !sdo_oe_n |-> $past(rd_frame && !cs_n_in))
    else $error("Serial output driven outside a read frame");
endmodule

// file: dv/mcr_host_model.sv
// Serial host model: 24-bit frames, clock idle low, MSB first.
// Assumes callers step it from the reference clock's falling edge.
`timescale 1ns/10ps
module mcr_host_model
(
  input wire logic ref_clk_in,
  input wire logic sdo_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic sdi_out
);
  // Idle levels at time zero
  initial
  begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
  end

  // Wait n falling edges of the reference clock
  task automatic step(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask

  // One frame of nclk serial clocks; each phase lasts two reference cycles
  task automatic xfer(input logic rd, input logic [6:0] addr, input logic [15:0] data,
                      input int nclk, output logic [15:0] q);
    logic [23:0] frame;
    frame = {rd, addr, data};
    q = 16'h0000;
    step(1);
    cs_n_out = 1'b0;
    step(2);
    for (int i = 0; i < nclk; i++)
    begin
      sclk_out = 1'b0;
      sdi_out = (i < 24) ? frame[23 - i] : 1'b0;
      step(2);
      sclk_out = 1'b1;
      if (i >= 8)
      begin
        q = {q[14:0], sdo_in};
      end
      step(2);
    end
    sclk_out = 1'b0;
    step(2);
    cs_n_out = 1'b1;
    sdi_out = ~sdi_out; // Released line must not keep its last level
    step(5); // Leaves room for the commit to reach the outputs
  endtask
endmodule

// file: dv/tb.sv
// Self-checking bench for the configuration and identity register bank.
// Assumes the host model frames every access and the bench feeds sense samples.
`timescale 1ns/10ps
module tb;
  localparam logic [15:0] PART = 16'h5e21; // Arbitrary value
  localparam logic [15:0] REV = 16'h0007; // Arbitrary value
  localparam logic [15:0] MAKER = 16'h6b19; // Arbitrary value
  logic ref_clk, sys_rst, sclk, cs_n, sdi, sdo, sdo_oe_n, sdo_line;
  logic [11:0] cs_sample, cs_filtered;
  logic cs_sample_valid, active_mode, trig_sel, loop_en;
  logic [2:0] rt_avg;
  int err_total, cmp_count;
  logic [6:0] id_ofs [3];
  logic [15:0] id_val [3];

  // Released data line shows the inverse, since no pull resistor holds it
  assign sdo_line = sdo_oe_n ? ~sdo : sdo;

  mcr_host_model host (.ref_clk_in(ref_clk), .sdo_in(sdo_line), .sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi));

  mcr_regs #(.PART_CODE(PART), .REVISION_CODE(REV), .MAKER_CODE(MAKER)) dut
  (
    .ref_clk_in(ref_clk),
    .sys_rst_in(sys_rst),
    .sclk_in(sclk),
    .cs_n_in(cs_n),
    .sdi_in(sdi),
    .sdo_out(sdo),
    .sdo_oe_n_out(sdo_oe_n),
    .cs_sample_in(cs_sample),
    .cs_sample_valid_in(cs_sample_valid),
    .cs_filtered_out(cs_filtered),
    .active_mode_out(active_mode),
    .conversion_trigger_select_out(trig_sel),
    .remote_temp_average_select_out(rt_avg),
    .loop_enable_out(loop_en)
  );

  // 125 MHz reference clock
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d, input int n);
    logic [15:0] q;
    host.xfer(1'b0, a, d, n, q);
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] q;
    host.xfer(1'b1, a, 16'h0000, 24, q);
    chk(q, exp);
  endtask

  // Single sample strobe, then compare the filtered value
  task automatic sense(input logic [11:0] x, input logic [11:0] exp);
    @(negedge ref_clk);
    cs_sample = x;
    cs_sample_valid = 1'b1;
    @(negedge ref_clk);
    cs_sample_valid = 1'b0;
    @(negedge ref_clk);
    chk({4'h0, cs_filtered}, {4'h0, exp});
  endtask

  task automatic tally_and_finish();
    $display("compares=%0d mismatches=%0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Hang guard, well above the roughly 5100 cycles the tests need
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    $display("ERROR t=%0t watchdog got=%h exp=%h", $time, 1'b0, 1'b1);
    err_total++;
    tally_and_finish();
  end

  initial
  begin
    sys_rst = 1'b1;
    cs_sample = 12'h000;
    cs_sample_valid = 1'b0;
    err_total = 0;
    cmp_count = 0;
    id_ofs = '{mcr_pkg::OFS_PART_IDENTITY, mcr_pkg::OFS_REVISION_IDENTITY, mcr_pkg::OFS_MAKER_IDENTITY};
    id_val = '{PART, REV, MAKER};
    repeat (3) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge ref_clk);
    // Reset values of registers and decoded outputs
    chk({10'h000, active_mode, trig_sel, rt_avg, loop_en}, 16'h0000);
    rd_chk(mcr_pkg::OFS_POWER_STATE, 16'h0000);
    rd_chk(mcr_pkg::OFS_GENERAL_CONFIG_ZERO, 16'h0300);
    $display("test reset_values done");
    // Identity registers are fixed and ignore writes
    for (int i = 0; i < 3; i++)
    begin
      rd_chk(id_ofs[i], id_val[i]);
      wr(id_ofs[i], ~id_val[i], 24);
      rd_chk(id_ofs[i], id_val[i]);
    end
    rd_chk(7'h05, 16'h0000);
    $display("test identity done");
    // Every legal power code; only 10 is active
    for (int c = 0; c < 3; c++)
    begin
      wr(mcr_pkg::OFS_POWER_STATE, 16'(c), 24);
      rd_chk(mcr_pkg::OFS_POWER_STATE, 16'(c));
      chk(16'(active_mode), (c == 2) ? 16'h0001 : 16'h0000);
    end
    $display("test power_codes done");
    // Field decode and reserved bits stored
    wr(mcr_pkg::OFS_GENERAL_CONFIG_ZERO, 16'h1451, 24);
    rd_chk(mcr_pkg::OFS_GENERAL_CONFIG_ZERO, 16'h1451);
    chk({10'h000, active_mode, trig_sel, rt_avg, loop_en}, 16'h003b);
    wr(mcr_pkg::OFS_GENERAL_CONFIG_ZERO, 16'he88f, 24);
    rd_chk(mcr_pkg::OFS_GENERAL_CONFIG_ZERO, 16'he88f);
    chk({10'h000, active_mode, trig_sel, rt_avg, loop_en}, 16'h0021);
    for (int c = 0; c < 6; c++)
    begin
      wr(mcr_pkg::OFS_GENERAL_CONFIG_ZERO, 16'h0300 | 16'(c << 4), 24);
      chk(16'(rt_avg), 16'(c));
    end
    $display("test config_fields done");
    // Depth K: code 000 loads the sample outright, then one step of depth K
    for (int k = 0; k < 5; k++)
    begin
      wr(mcr_pkg::OFS_GENERAL_CONFIG_ZERO, 16'h0000, 24);
      sense(12'h000, 12'h000);
      wr(mcr_pkg::OFS_GENERAL_CONFIG_ZERO, 16'(k << 8), 24);
      sense(12'h400, 12'h400 >> k);
    end
    sense(12'h400, 12'h07c);
    wr(mcr_pkg::OFS_POWER_STATE, 16'h0000, 24);
    sense(12'h000, 12'h07c);
    $display("test sense_filter done");
    // Mid-run reset returns registers and outputs to their reset values
    wr(mcr_pkg::OFS_POWER_STATE, 16'h0002, 24);
    wr(mcr_pkg::OFS_GENERAL_CONFIG_ZERO, 16'h1451, 24);
    sys_rst = 1'b1;
    repeat (3) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk({10'h000, active_mode, trig_sel, rt_avg, loop_en}, 16'h0000);
    chk({4'h0, cs_filtered}, 16'h0000);
    chk(16'(sdo_oe_n), 16'h0001);
    rd_chk(mcr_pkg::OFS_POWER_STATE, 16'h0000);
    rd_chk(mcr_pkg::OFS_GENERAL_CONFIG_ZERO, 16'h0300);
    $display("test mid_reset done");
    // Short and long write frames are dropped
    wr(mcr_pkg::OFS_GENERAL_CONFIG_ZERO, 16'h0300, 24);
    wr(mcr_pkg::OFS_GENERAL_CONFIG_ZERO, 16'h1451, 23);
    rd_chk(mcr_pkg::OFS_GENERAL_CONFIG_ZERO, 16'h0300);
    wr(mcr_pkg::OFS_GENERAL_CONFIG_ZERO, 16'h1451, 25);
    rd_chk(mcr_pkg::OFS_GENERAL_CONFIG_ZERO, 16'h0300);
    chk({10'h000, active_mode, trig_sel, rt_avg, loop_en}, 16'h0000);
    $display("test frame_length done");
    tally_and_finish();
  end
endmodule
